// ==== hdl/pwm_duty_limit_saturation.sv ====
// How it works
// [R1] duty capped at N/64, N from limit register bits 7:2.
// [R2] limit bit 1 enables high saturation, bit 0 low saturation.
// [R3] big transient forces duty to zero or limit by error sign.
// [R4] error inside window moves duty through the filter gradually.
// [R5] error leaving window reaches the extreme within one cycle.
// [R6] compensation is third order: three zeros, three poles.
// [R7] four numerator and three denominator coefficients, all programmable.
// [R8] numerators in high/low byte pairs, denominators single registers.
// [R9] host sets limit somewhat above steady-state duty.
// [R10] host disables saturation or keeps limit at 120-140 percent.
// [R11] host avoids saturation above 2.0 V output.
// [R12] converters exchange share signal and equalise output current.
// [R13] load regulation is kept per converter, independent of others.
// [R14] host gives one paralleled converter small load regulation.
// [R15] new limit and enables take effect at next cycle start.
// [R16] output duty never exceeds the programmed limit.
module pwm_duty_limit_saturation
  import pwm_duty_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire reg_wr_t reg_wr,
  input wire logic [3:0] reg_rd_addr,
  output logic [7:0] reg_rdata,
  input wire logic signed [7:0] err_in,
  input wire logic [5:0] cur_sense,
  input wire logic share_in,
  output logic share_out,
  output logic share_oe_b,
  output logic pwm_out,
  output logic [5:0] duty,
  output logic cycle_start
);
  // ****************************
  // helpers
  // ****************************
  function automatic logic [7:0] reg_reset(input int idx);
    return (idx == int'(IDX_LIMIT)) ? LIMIT_RST
         : (idx == int'(IDX_WINDOW)) ? WINDOW_RST
         : COEF_RST;
  endfunction : reg_reset
  function automatic logic signed [15:0] sat16(
    input logic signed [27:0] v
  );
    if (v > 28'sd32767) begin
      return 16'sh7FFF;
    end
    if (v < -28'sd32768) begin
      return 16'sh8000;
    end
    return v[15:0];
  endfunction : sat16
  // ****************************
  // register file
  // ****************************
  logic [7:0] regs_q [REG_COUNT];
  logic [7:0] regs_d [REG_COUNT];
  logic [7:0] reg_rdata_q, reg_rdata_d;
  logic [7:0] status;
  // host writes and read mux
  always_comb begin
    regs_d = regs_q;
    // [R8] coefficient byte writes
    if (reg_wr.we && (int'(reg_wr.addr) < REG_COUNT)) begin
      regs_d[reg_wr.addr] = reg_wr.data;
    end
    if (int'(reg_rd_addr) < REG_COUNT) begin
      reg_rdata_d = regs_q[reg_rd_addr];
    end else if (reg_rd_addr == IDX_STATUS) begin
      reg_rdata_d = status;
    end else begin
      reg_rdata_d = 8'h00;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= reg_reset(i);
      end
      reg_rdata_q <= 8'h00;
    end else begin
      regs_q <= regs_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end
  // ****************************
  // switching cycle and shadows
  // ****************************
  logic [5:0] cyc_q, cyc_d;
  logic [5:0] lim_q, lim_d;
  logic hi_q, hi_d, lo_q, lo_d;
  logic cycle_end;
  assign cycle_end = (cyc_q == CYC_LAST);
  // cycle counter, settings latched at boundary
  always_comb begin
    cyc_d = cyc_q + 6'h01;
    lim_d = lim_q;
    hi_d = hi_q;
    lo_d = lo_q;
    // [R15] apply at cycle start
    if (cycle_end) begin
      lim_d = regs_q[IDX_LIMIT][7:LIMIT_LSB];
      // [R2] saturation enable bits
      hi_d = regs_q[IDX_LIMIT][HI_BIT];
      lo_d = regs_q[IDX_LIMIT][LO_BIT];
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_q <= 6'h00;
      lim_q <= LIMIT_RST[7:LIMIT_LSB];
      hi_q <= LIMIT_RST[HI_BIT];
      lo_q <= LIMIT_RST[LO_BIT];
    end else begin
      cyc_q <= cyc_d;
      lim_q <= lim_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end
  // ****************************
  // compensation filter
  // ****************************
  logic signed [7:0] e_q [3];
  logic signed [7:0] e_d [3];
  logic signed [15:0] u_q [3];
  logic signed [15:0] u_d [3];
  logic signed [15:0] num [4];
  logic signed [7:0] den [3];
  logic signed [27:0] acc;
  logic signed [15:0] u_new;
  // [R7] coefficient assembly
  for (genvar k = 0; k < 4; k++) begin : g_num
    assign num[k] = {regs_q[int'(IDX_C0H) + 2 * k],
                     regs_q[int'(IDX_C0L) + 2 * k]};
  end
  for (genvar k = 0; k < 3; k++) begin : g_den
    assign den[k] = regs_q[int'(IDX_B1) + k];
  end
  // [R6] three zeros, three poles
  always_comb begin
    acc = 28'(num[0] * err_in) + 28'(num[1] * e_q[0])
        + 28'(num[2] * e_q[1]) + 28'(num[3] * e_q[2])
        - 28'(den[0] * u_q[0]) - 28'(den[1] * u_q[1])
        - 28'(den[2] * u_q[2]);
    u_new = sat16(acc >>> ACC_SHIFT);
    e_d = e_q;
    u_d = u_q;
    if (cycle_end) begin
      e_d[0] = err_in;
      e_d[1] = e_q[0];
      e_d[2] = e_q[1];
      u_d[0] = u_new;
      u_d[1] = u_q[0];
      u_d[2] = u_q[1];
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 3; i++) begin
        e_q[i] <= 8'sh00;
        u_q[i] <= 16'sh0000;
      end
    end else begin
      e_q <= e_d;
      u_q <= u_d;
    end
  end
  // ****************************
  // current share line
  // ****************************
  logic share_m_q, share_s_q;
  logic [5:0] low_cnt_q, low_cnt_d;
  logic [3:0] trim_q, trim_d;
  logic share_oe_b_q, share_oe_b_d;
  // [R12] drive low for own current, trim to follow the highest
  always_comb begin
    share_oe_b_d = !(cyc_d < cur_sense);
    low_cnt_d = cycle_end ? 6'h00 : low_cnt_q + 6'(!share_s_q);
    trim_d = trim_q;
    if (cycle_end) begin
      if ((low_cnt_q > cur_sense) && (trim_q != TRIM_MAX)) begin
        trim_d = trim_q + 4'h1;
      end else if ((low_cnt_q <= cur_sense) && (trim_q != 4'h0)) begin
        trim_d = trim_q - 4'h1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      share_m_q <= 1'b1;
      share_s_q <= 1'b1;
      low_cnt_q <= 6'h00;
      trim_q <= 4'h0;
      share_oe_b_q <= 1'b1;
    end else begin
      share_m_q <= share_in;
      share_s_q <= share_m_q;
      low_cnt_q <= low_cnt_d;
      trim_q <= trim_d;
      share_oe_b_q <= share_oe_b_d;
    end
  end
  // ****************************
  // duty selection
  // ****************************
  sat_mode_t sat_q, sat_d;
  logic [5:0] duty_q, duty_d;
  logic [5:0] lin_duty;
  logic pwm_q, pwm_d;
  logic signed [8:0] win;
  logic signed [9:0] mix;
  logic [13:0] droop;
  assign win = 9'(signed'({1'b0, regs_q[IDX_WINDOW]}));
  // linear path: filter output, load regulation, share trim
  always_comb begin
    // [R13] own load regulation droop
    droop = regs_q[IDX_LOAD_REG] * cur_sense;
    if (u_new[15]) begin
      mix = 10'sh000;
    end else if (u_new[14:DUTY_SHIFT] > 9'd63) begin
      mix = 10'sd63;
    end else begin
      mix = 10'(signed'({1'b0, u_new[14:DUTY_SHIFT]}));
    end
    mix = mix + 10'(signed'({1'b0, trim_q}))
        - 10'(signed'({1'b0, droop[13:DUTY_SHIFT]}));
    // [R16] clamp to the new limit
    if (mix < 10'sh000) begin
      lin_duty = 6'h00;
    end else if (mix > 10'(signed'({1'b0, lim_d}))) begin
      lin_duty = lim_d;
    end else begin
      lin_duty = mix[5:0];
    end
  end
  // saturation window and duty update
  always_comb begin
    sat_d = sat_q;
    duty_d = duty_q;
    if (cycle_end) begin
      // [R3] error sign picks extreme
      if (hi_d && (9'(err_in) > win)) begin
        sat_d = SAT_HIGH;
      end else if (lo_d && (9'(err_in) < -win)) begin
        sat_d = SAT_LOW;
      end else begin
        sat_d = SAT_NONE;
      end
      // [R5] extreme in one cycle
      case (sat_d)
        SAT_HIGH: duty_d = lim_d;
        SAT_LOW: duty_d = 6'h00;
        // [R4] gradual inside window
        SAT_NONE: duty_d = lin_duty;
        default: duty_d = 6'h00;
      endcase
    end
    // [R1] pwm high for duty of 64 ticks
    pwm_d = (cyc_d < duty_d);
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sat_q <= SAT_NONE;
      duty_q <= 6'h00;
      pwm_q <= 1'b0;
    end else begin
      sat_q <= sat_d;
      duty_q <= duty_d;
      pwm_q <= pwm_d;
    end
  end
  // ****************************
  // outputs
  // ****************************
  logic cstart_q;
  assign status = {2'b00, sat_q, trim_q};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cstart_q <= 1'b0;
    end else begin
      cstart_q <= cycle_end;
    end
  end
  assign reg_rdata = reg_rdata_q;
  assign share_out = 1'b0;
  assign share_oe_b = share_oe_b_q;
  assign pwm_out = pwm_q;
  assign duty = duty_q;
  assign cycle_start = cstart_q;
  // ****************************
  // checks
  // ****************************
  AST_DUTY_CAP: assert property ( // [R16]
    @(posedge core_clk) disable iff (!rst_b) duty_q <= lim_q)
    else $error("duty above limit");

  AST_PWM_WIDTH: assert property ( // [R1]
    @(posedge core_clk) disable iff (!rst_b) pwm_q == (cyc_q < duty_q))
    else $error("pwm width differs from duty");

  AST_LIMIT_HOLD: assert property ( // [R15]
    @(posedge core_clk) disable iff (!rst_b)
    !cycle_end |=> $stable(lim_q) && $stable(hi_q) && $stable(duty_q))
    else $error("setting changed mid cycle");

  AST_SAT_HIGH: assert property ( // [R5]
    @(posedge core_clk) disable iff (!rst_b)
    cycle_end && regs_q[IDX_LIMIT][HI_BIT] && (9'(err_in) > win)
    |=> duty_q == lim_q && pwm_q == (lim_q != 6'h00))
    else $error("high saturation missed");

  AST_SAT_LOW: assert property ( // [R3]
    @(posedge core_clk) disable iff (!rst_b)
    cycle_end && regs_q[IDX_LIMIT][LO_BIT] && (9'(err_in) < -win)
    && !(regs_q[IDX_LIMIT][HI_BIT] && (9'(err_in) > win))
    |=> duty_q == 6'h00 && !pwm_q)
    else $error("low saturation missed");

  AST_SAT_ENABLE: assert property ( // [R2]
    @(posedge core_clk) disable iff (!rst_b)
    (sat_q == SAT_HIGH |-> hi_q) and (sat_q == SAT_LOW |-> lo_q))
    else $error("saturation while disabled");

  AST_LINEAR: assert property ( // [R4]
    @(posedge core_clk) disable iff (!rst_b)
    cycle_end && sat_d == SAT_NONE |=> duty_q == $past(lin_duty))
    else $error("linear duty not applied");

  AST_COEF_WRITE: assert property ( // [R8]
    @(posedge core_clk) disable iff (!rst_b)
    reg_wr.we && reg_wr.addr == IDX_B1
    |=> regs_q[IDX_B1] == $past(reg_wr.data))
    else $error("coefficient write lost");
endmodule : pwm_duty_limit_saturation

// ==== hdl/pwm_duty_pkg.sv ====
package pwm_duty_pkg;

  // ****************************
  // register indices
  // ****************************
  localparam int REG_COUNT = 14;
  localparam logic [3:0] IDX_LIMIT = 4'h0;
  localparam logic [3:0] IDX_C0H = 4'h1;
  localparam logic [3:0] IDX_C0L = 4'h2;
  localparam logic [3:0] IDX_B1 = 4'h9;
  localparam logic [3:0] IDX_B2 = 4'hA;
  localparam logic [3:0] IDX_B3 = 4'hB;
  localparam logic [3:0] IDX_WINDOW = 4'hC;
  localparam logic [3:0] IDX_LOAD_REG = 4'hD;
  localparam logic [3:0] IDX_STATUS = 4'hE;

  // ****************************
  // fields and reset values
  // ****************************
  localparam int LIMIT_LSB = 2;
  localparam int HI_BIT = 1;
  localparam int LO_BIT = 0;
  localparam logic [7:0] LIMIT_RST = 8'hE8;
  localparam logic [7:0] WINDOW_RST = 8'h10;
  localparam logic [7:0] COEF_RST = 8'h00;

  // ****************************
  // timing and arithmetic
  // ****************************
  localparam logic [5:0] CYC_LAST = 6'h3F;
  localparam logic [3:0] TRIM_MAX = 4'hF;
  localparam int ACC_SHIFT = 8;
  localparam int DUTY_SHIFT = 6;

  // ****************************
  // types
  // ****************************
  typedef struct packed {
    logic we;
    logic [3:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  typedef enum logic [1:0] {
    SAT_NONE = 2'b00,
    SAT_HIGH = 2'b01,
    SAT_LOW = 2'b10
  } sat_mode_t;

endpackage : pwm_duty_pkg

// ==== tb/share_peer.sv ====
module share_peer (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cycle_start,
  input wire logic [5:0] peer_cur,
  output logic peer_oe_b
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [6:0] tick_q;

  // ticks since the design's cycle start, parked at 64
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= 7'h40;
    end else if (cycle_start) begin
      tick_q <= 7'h01;
    end else if (tick_q != 7'h40) begin
      tick_q <= tick_q + 7'h01;
    end
  end

  // pull line low for own current ticks
  assign peer_oe_b = cycle_start ? (peer_cur == 6'h00)
                                 : ({1'b0, peer_cur} <= tick_q);

endmodule : share_peer

// ==== tb/pwm_duty_limit_saturation_test.sv ====
module pwm_duty_limit_saturation_test
  import pwm_duty_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************
  // signals and instances
  // ****************************
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  reg_wr_t reg_wr;
  logic [3:0] reg_rd_addr;
  logic [7:0] reg_rdata, v;
  logic signed [7:0] err_in;
  logic [5:0] cur_sense, duty, peer_cur;
  logic share_in, share_out, share_oe_b, pwm_out, cycle_start, peer_oe_b;
  int fail_count = 0;
  int compares = 0;

  always #5 core_clk = ~core_clk;
  // open-drain line with pull-up
  assign share_in = share_oe_b & peer_oe_b;

  pwm_duty_limit_saturation i_pwm_duty_limit_saturation (
    .core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd_addr(reg_rd_addr), .reg_rdata(reg_rdata), .err_in(err_in),
    .cur_sense(cur_sense), .share_in(share_in), .share_out(share_out),
    .share_oe_b(share_oe_b), .pwm_out(pwm_out), .duty(duty),
    .cycle_start(cycle_start)
  );

  share_peer i_share_peer (
    .core_clk(core_clk), .rst_b(rst_b), .cycle_start(cycle_start),
    .peer_cur(peer_cur), .peer_oe_b(peer_oe_b)
  );

  // ****************************
  // shared tasks
  // ****************************
  task automatic finish_test();
    $display("counts: compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [7:0] exp, got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr = '{we: 1'b1, addr: a, data: d};
    tick(1);
    reg_wr.we = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    reg_rd_addr = a;
    tick(1);
    v = reg_rdata;
  endtask : rd

  task automatic wait_cs();
    for (int i = 0; i < 130; i++) begin
      tick(1);
      if (cycle_start === 1'b1) return;
    end
    fail_count++;
    $display("[FAIL] cycle_start expected 1 seen timeout");
    finish_test();
  endtask : wait_cs

  // pwm high ticks and own share drive ticks over one cycle
  task automatic measure(output logic [7:0] hi, output logic [7:0] lo);
    hi = 8'h00;
    lo = 8'h00;
    for (int i = 0; i < 64; i++) begin
      if (i != 0) tick(1);
      hi = hi + {7'h00, pwm_out === 1'b1};
      lo = lo + {7'h00, share_oe_b === 1'b0};
    end
  endtask : measure

  task automatic run_cycle(input string name, input logic [7:0] exp);
    logic [7:0] hi, lo;
    wait_cs();
    wait_cs();
    chk(name, exp, {2'b00, duty});
    measure(hi, lo);
    chk("pwm_high_ticks", exp, hi);
  endtask : run_cycle

  // ****************************
  // scenarios
  // ****************************
  task automatic t_reset();
    chk("duty_rst", 8'h00, {2'b00, duty});
    rd(IDX_LIMIT);
    chk("limit_rst", LIMIT_RST, v);
    rd(IDX_WINDOW);
    chk("window_rst", WINDOW_RST, v);
    rd(4'hF);
    chk("idx15", 8'h00, v);
    wr(IDX_STATUS, 8'hFF);
    rd(IDX_STATUS);
    chk("status_ro", 8'h00, v);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    for (int k = 1; k < 12; k++) wr(4'(k), {4'(k), 4'(~k)});
    for (int k = 1; k < 12; k++) begin
      rd(4'(k));
      chk("coef_rb", {4'(k), 4'(~k)}, v);
      wr(4'(k), COEF_RST);
    end
    $display("test registers done");
  endtask : t_regs

  task automatic t_linear();
    wr(IDX_C0H, 8'h40);
    wr(IDX_LIMIT, 8'hA2);
    err_in = 8'sh0A;
    run_cycle("duty_lin", 8'h0A);
    wr(IDX_LIMIT, 8'hA0);
    err_in = 8'sh32;
    run_cycle("duty_cap", 8'h28);
    $display("test linear done");
  endtask : t_linear

  task automatic t_sat();
    wr(IDX_C0H, 8'h00);
    wr(IDX_LIMIT, 8'hA2);
    err_in = 8'sh00;
    run_cycle("duty_zero", 8'h00);
    wait_cs();
    err_in = 8'sh7F;
    wait_cs();
    chk("sat_high", 8'h28, {2'b00, duty});
    wr(IDX_LIMIT, 8'hC2);
    chk("limit_held", 8'h28, {2'b00, duty});
    wait_cs();
    chk("limit_new", 8'h30, {2'b00, duty});
    wr(IDX_C0H, 8'hC0);
    wr(IDX_LIMIT, 8'hA0);
    err_in = 8'shEC;
    run_cycle("duty_neg", 8'h14);
    wr(IDX_LIMIT, 8'hA1);
    run_cycle("sat_low", 8'h00);
    rd(IDX_STATUS);
    chk("sat_mode", {6'h00, SAT_LOW}, {6'h00, v[5:4]});
    $display("test saturation done");
  endtask : t_sat

  task automatic t_share();
    logic [7:0] hi, lo;
    cur_sense = 6'h03;
    wait_cs();
    measure(hi, lo);
    chk("share_ticks", 8'h03, lo);
    peer_cur = 6'h14;
    repeat (3) wait_cs();
    rd(IDX_STATUS);
    chk("trim_up", 8'h01, {7'h00, v[3:0] != 4'h0});
    chk("share_out", 8'h00, {7'h00, share_out});
    $display("test share done");
  endtask : t_share

  // trim from a higher peer, own droop, switching period
  task automatic t_trim();
    int n;
    n = 0;
    wr(IDX_LIMIT, 8'hA0);
    wr(IDX_C0H, 8'h40);
    err_in = 8'sh0A;
    peer_cur = 6'h14;
    repeat (16) wait_cs();
    run_cycle("duty_trim", 8'h19);
    wait_cs();
    for (int i = 0; i < 130 && n == 0; i++) begin
      tick(1);
      if (cycle_start === 1'b1) n = i + 1;
    end
    chk("cycle_ticks", 8'h40, 8'(n));
    peer_cur = 6'h00;
    wr(IDX_LOAD_REG, 8'h40);
    repeat (16) wait_cs();
    run_cycle("duty_droop", 8'h07);
    $display("test trim done");
  endtask : t_trim

  // ****************************
  // main sequence
  // ****************************
  initial begin
    reg_wr = '0;
    reg_rd_addr = 4'h0;
    err_in = 8'sh00;
    cur_sense = 6'h00;
    peer_cur = 6'h00;
    tick(3);
    rst_b = 1'b1;
    t_reset();
    t_regs();
    t_linear();
    t_sat();
    t_share();
    t_trim();
    finish_test();
  end

endmodule : pwm_duty_limit_saturation_test
